/* rtl/fos_operand_gen.v */
// Flexible second operand generator, registered outputs toward the ALU.
// Assumes decoder inputs are synchronous and valid with op_valid_in.
`timescale 1ns/1ps
`include "fos_regs.vh"
module fos_operand_gen #(
  parameter W = 32
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire op_valid_in,
  input wire [2:0] op_sel_in,
  input wire [7:0] imm_byte_in,
  input wire [4:0] imm_pos_in,
  input wire [W-1:0] source_operand_register_in,
  input wire [2:0] shift_kind_in,
  input wire [7:0] shift_amt_in,
  input wire set_flags_in,
  input wire carry_flag_in,
  input wire [W-1:0] pc_load_addr_in,
  input wire pc_load_in,
  output reg op_valid_out,
  output reg [W-1:0] flexible_second_operand_out,
  output reg carry_update_out,
  output reg carry_value_out,
  output reg iset_fault_out
);
  // Operand source codes, the through-carry shift code and the byte limit, mirrored from the shared constants header.
  localparam [2:0] SEL_IMM_SHIFT = `FOS_SEL_IMM_SHIFT;
  localparam [2:0] SEL_IMM_LO = `FOS_SEL_IMM_LO;
  localparam [2:0] SEL_IMM_HI = `FOS_SEL_IMM_HI;
  localparam [2:0] SEL_IMM_ALL = `FOS_SEL_IMM_ALL;
  localparam [2:0] SEL_REG = `FOS_SEL_REG;
  localparam [2:0] SH_RRX = `FOS_SH_RRX;
  localparam [31:0] BYTE_MAX = `FOS_BYTE_MAX;

  // The source value is only read here; no path exists back to the file.
  wire [W-1:0] sh_res;
  wire sh_carry;
  wire sh_changed;
  wire sel_imm_shift;
  wire sel_repl;
  wire sel_reg;
  wire no_shift;
  reg [W-1:0] imm_val;
  reg imm_upd;
  reg [W-1:0] reg_val;
  reg reg_upd;
  reg [W-1:0] op_d;
  reg upd_d;
  reg cy_d;
  reg valid_d;
  reg upd_gate_d;
  reg cy_out_d;
  reg fault_d;

  // Bits pushed past the top of the word are dropped, so an encoder must
  // keep the whole byte inside the word to get the constant it intends.
  function [W-1:0] place_byte;
    input [7:0] value;
    input [4:0] pos;
    reg [2*W-1:0] wide;
    begin
      wide = {{(2*W-8){1'b0}}, value} << pos;
      place_byte = wide[W-1:0];
    end
  endfunction

  // Selects that are not replicated forms read as zero here.
  function [W-1:0] repl_byte;
    input [2:0] sel;
    input [7:0] value;
    begin
      case (sel)
        SEL_IMM_LO: repl_byte = {8'h00, value, 8'h00, value};
        SEL_IMM_HI: repl_byte = {value, 8'h00, value, 8'h00};
        SEL_IMM_ALL: repl_byte = {value, value, value, value};
        default: repl_byte = {W{1'b0}};
      endcase
    end
  endfunction

  function is_wide_const;
    input [W-1:0] value;
    begin
      is_wide_const = (value > BYTE_MAX);
    end
  endfunction

  // A zero length on any shift but the one-bit rotate leaves the source.
  function is_null_shift;
    input [2:0] kind;
    input [7:0] amt;
    begin
      is_null_shift = (kind != SH_RRX) && (amt == 8'h00);
    end
  endfunction

  // Only the compact instruction set exists, so an even target faults.
  function iset_bad;
    input [W-1:0] addr;
    begin
      iset_bad = ~addr[`FOS_ISET_BIT];
    end
  endfunction

  function carry_pick;
    input take_new;
    input new_carry;
    input old_carry;
    begin
      carry_pick = take_new ? new_carry : old_carry;
    end
  endfunction

  // The shifter is purely combinational; its carry is only used when the
  // register form is selected.
  fos_shifter #(.W(W)) u_shift (
    .src_in(source_operand_register_in),
    .kind_in(shift_kind_in),
    .amt_in(shift_amt_in),
    .carry_in(carry_flag_in),
    .res_out(sh_res),
    .carry_out(sh_carry),
    .changed_out(sh_changed)
  );

  assign sel_imm_shift = (op_sel_in == SEL_IMM_SHIFT);
  assign sel_repl = (op_sel_in == SEL_IMM_LO) ||
    (op_sel_in == SEL_IMM_HI) || (op_sel_in == SEL_IMM_ALL);
  assign sel_reg = (op_sel_in == SEL_REG);
  assign no_shift = is_null_shift(shift_kind_in, shift_amt_in);

  always @* begin
    imm_val = {W{1'b0}};
    imm_upd = 1'b0;
    if (sel_imm_shift) begin
      imm_val = place_byte(imm_byte_in, imm_pos_in);
      // Only a shifted constant wider than one byte may move the carry.
      imm_upd = is_wide_const(imm_val);
    end else if (sel_repl) begin
      imm_val = repl_byte(op_sel_in, imm_byte_in);
      imm_upd = 1'b0;
    end
  end

  always @* begin
    reg_val = sh_res;
    reg_upd = 1'b0;
    if (no_shift) begin
      reg_val = source_operand_register_in;
    end else begin
      reg_upd = sh_changed;
    end
  end

  always @* begin
    op_d = reg_val;
    upd_d = 1'b0;
    cy_d = carry_flag_in;
    // Unknown selects fall back to the register path with no carry write.
    if (sel_imm_shift || sel_repl) begin
      op_d = imm_val;
      upd_d = set_flags_in & imm_upd;
      cy_d = carry_pick(imm_upd, imm_val[W-1], carry_flag_in);
    end else if (sel_reg) begin
      upd_d = set_flags_in & reg_upd;
      cy_d = carry_pick(reg_upd, sh_carry, carry_flag_in);
    end
  end

  // The carry is only offered for an accepted request, so a stale select
  // on an idle cycle can never leak a carry write into the flags.
  always @* begin
    valid_d = op_valid_in;
    upd_gate_d = op_valid_in & upd_d;
    cy_out_d = carry_pick(upd_gate_d, cy_d, carry_flag_in);
    fault_d = pc_load_in & iset_bad(pc_load_addr_in);
  end

  // Each output has a register of its own, so every port is a flop and
  // the reset value of each one can be read at a glance.
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_valid_out <= 1'b0;
    end else begin
      op_valid_out <= valid_d;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flexible_second_operand_out <= `FOS_RESET_WORD;
    end else begin
      flexible_second_operand_out <= op_d;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      carry_update_out <= 1'b0;
    end else begin
      carry_update_out <= upd_gate_d;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      carry_value_out <= 1'b0;
    end else begin
      carry_value_out <= cy_out_d;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      iset_fault_out <= 1'b0;
    end else begin
      iset_fault_out <= fault_d;
    end
  end
endmodule // fos_operand_gen

/* rtl/fos_regs.vh */
// Constants for the flexible second operand generator.
// Assumes a 32-bit datapath fed by the decoder and register file.
// Contract
// - Branch target bit 0 must be one.
// - Expand 8-bit value shifted anywhere in word.
// - Expand replicated byte patterns, three forms.
// - Shifted constant above 255 sets carry bit 31.
// - Other constants leave carry unchanged.
// - Arithmetic and logical right shifts 1..32.
// - Left shift and rotate 1..31.
// - Rotate right through carry by one.
// - No shift passes source through.
// - Shift never writes source register back.
// - Flag-setting shifts update carry.
// - Arithmetic right fills bit 31, carry n-1.
// - Logical shifts zero fill, carry rules.
// - Rotate by 32 identity, above wraps.
// - Through-carry inserts carry, carry gets bit 0.
`ifndef FOS_REGS_VH
`define FOS_REGS_VH
`define FOS_SEL_IMM_SHIFT 3'h0
`define FOS_SEL_IMM_LO 3'h1
`define FOS_SEL_IMM_HI 3'h2
`define FOS_SEL_IMM_ALL 3'h3
`define FOS_SEL_REG 3'h4
`define FOS_SH_LSL 3'h0
`define FOS_SH_LSR 3'h1
`define FOS_SH_ASR 3'h2
`define FOS_SH_ROR 3'h3
`define FOS_SH_RRX 3'h4
`define FOS_BYTE_MAX 32'h000000FF
`define FOS_ISET_BIT 0
`define FOS_RESET_WORD 32'h00000000
`endif

/* rtl/fos_shifter.v */
// Combinational barrel shifter producing a value and a carry-out.
// Assumes the amount is already the encoded shift length.
`timescale 1ns/1ps
`include "fos_regs.vh"
module fos_shifter #(
  parameter W = 32
) (
  input wire [W-1:0] src_in,
  input wire [2:0] kind_in,
  input wire [7:0] amt_in,
  input wire carry_in,
  output reg [W-1:0] res_out,
  output reg carry_out,
  output reg changed_out
);
  reg [2*W-1:0] wide;
  reg [7:0] n;
  always @* begin
    res_out = src_in;
    carry_out = carry_in;
    changed_out = 1'b0;
    wide = {2*W{1'b0}};
    n = amt_in;
    case (kind_in)
      `FOS_SH_LSL: begin
        if (n != 8'h00) begin
          changed_out = 1'b1;
          wide = {{W{1'b0}}, src_in} << n;
          res_out = (n >= W) ? {W{1'b0}} : wide[W-1:0];
          carry_out = (n > W) ? 1'b0 : wide[W];
        end
      end
      `FOS_SH_LSR, `FOS_SH_ASR: begin
        if (n != 8'h00) begin
          changed_out = 1'b1;
          if (kind_in == `FOS_SH_ASR) begin
            wide = $signed({src_in, {W{1'b0}}}) >>> n;
          end else begin
            wide = {src_in, {W{1'b0}}} >> n;
          end
          if (n >= W) begin
            res_out = (kind_in == `FOS_SH_ASR) ? {W{src_in[W-1]}} :
              {W{1'b0}};
            carry_out = (kind_in == `FOS_SH_ASR || n == W) ?
              src_in[W-1] : 1'b0;
          end else begin
            res_out = wide[2*W-1:W];
            carry_out = wide[W-1];
          end
        end
      end
      `FOS_SH_ROR: begin
        if (n != 8'h00) begin
          changed_out = 1'b1;
          n = {3'b000, amt_in[4:0]};
          wide = {src_in, src_in} >> n;
          res_out = wide[W-1:0];
          carry_out = res_out[W-1];
        end
      end
      `FOS_SH_RRX: begin
        changed_out = 1'b1;
        res_out = {carry_in, src_in[W-1:1]};
        carry_out = src_in[0];
      end
      default: begin
        res_out = src_in;
      end
    endcase
  end
endmodule // fos_shifter

/* tb/fos_regfile_model.sv */
// Source register file feeding the operand generator.
// Written only by the bench; reads are combinational.
`timescale 1ns/1ps
module fos_regfile_model (
  input wire clk_in,
  input wire we_in,
  input wire [2:0] idx_in,
  input wire [31:0] wd_in,
  output wire [31:0] rd_out
);
  reg [31:0] rf [0:7];
  always @(posedge clk_in) if (we_in) rf[idx_in] <= wd_in;
  assign rd_out = rf[idx_in];
endmodule // fos_regfile_model

/* tb/fos_checker.sv */
// Port checker for the operand generator.
// Bound to every fos_operand_gen instance.
`timescale 1ns/1ps
module fos_checker #(
  parameter W = 32
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire op_valid_in,
  input wire [2:0] op_sel_in,
  input wire [7:0] imm_byte_in,
  input wire [4:0] imm_pos_in,
  input wire [W-1:0] source_operand_register_in,
  input wire [2:0] shift_kind_in,
  input wire [7:0] shift_amt_in,
  input wire set_flags_in,
  input wire carry_flag_in,
  input wire [W-1:0] pc_load_addr_in,
  input wire pc_load_in,
  input wire op_valid_out,
  input wire [W-1:0] flexible_second_operand_out,
  input wire carry_update_out,
  input wire carry_value_out,
  input wire iset_fault_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_reg_op; op_valid_in && op_sel_in == 3'h4; endsequence
  sequence s_keep;
    !carry_update_out && carry_value_out == $past(carry_flag_in);
  endsequence
  a_fault_even: assert property (pc_load_in && !pc_load_addr_in[0] |=>
    iset_fault_out) else $error("fault missing");
  a_fault_odd: assert property (pc_load_in && pc_load_addr_in[0] |=>
    !iset_fault_out) else $error("spurious fault");
  a_valid_echo: assert property (op_valid_in |=> op_valid_out)
    else $error("valid lost");
  a_valid_drop: assert property (!op_valid_in |=> !op_valid_out)
    else $error("valid invented");
  a_noflag_keep: assert property (op_valid_in && !set_flags_in |=> s_keep)
    else $error("carry touched");
  a_repl_keep: assert property (op_valid_in && op_sel_in inside {3'h1,
    3'h2, 3'h3} |=> s_keep) else $error("repl carry");
  a_repl_all: assert property (op_valid_in && op_sel_in == 3'h3 |=>
    flexible_second_operand_out == {4{$past(imm_byte_in)}})
    else $error("bad byte fill");
  a_rrx_fill: assert property (s_reg_op ##0 shift_kind_in == 3'h4 |=>
    flexible_second_operand_out[31] == $past(carry_flag_in))
    else $error("rrx top bit");
  a_pass_thru: assert property (s_reg_op ##0 (shift_amt_in == 8'h00 &&
    shift_kind_in != 3'h4) |=> s_keep ##0 flexible_second_operand_out ==
    $past(source_operand_register_in)) else $error("no pass");
endmodule // fos_checker
bind fos_operand_gen fos_checker #(.W(W)) u_chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .op_valid_in(op_valid_in),
  .op_sel_in(op_sel_in),
  .imm_byte_in(imm_byte_in),
  .imm_pos_in(imm_pos_in),
  .source_operand_register_in(source_operand_register_in),
  .shift_kind_in(shift_kind_in),
  .shift_amt_in(shift_amt_in),
  .set_flags_in(set_flags_in),
  .carry_flag_in(carry_flag_in),
  .pc_load_addr_in(pc_load_addr_in),
  .pc_load_in(pc_load_in),
  .op_valid_out(op_valid_out),
  .flexible_second_operand_out(flexible_second_operand_out),
  .carry_update_out(carry_update_out),
  .carry_value_out(carry_value_out),
  .iset_fault_out(iset_fault_out)
);

/* tb/fos_operand_gen_tb.sv */
// Random operand bench; a queue of expected results is checked.
// Assumes the one-cycle registered answer of fos_operand_gen.
`timescale 1ns/1ps
module fos_operand_gen_tb;
  reg clk = 0, rst = 1, v = 0, sf = 0, cf = 0, pl = 0, we = 0;
  reg [2:0] sel = 0, kd = 0, ix = 0;
  reg [7:0] b = 0, n = 0;
  reg [4:0] p = 0;
  reg [31:0] pa = 0, wd = 0, g;
  reg [31:0] sh [0:7];
  reg [33:0] q [$];
  reg [33:0] e;
  wire [31:0] rm, op;
  wire vo, cu, cvo;
  integer miscompares = 0, checks = 0, i;
  always #5 clk = ~clk;
  fos_regfile_model rf (.clk_in(clk), .we_in(we), .idx_in(ix), .wd_in(wd),
    .rd_out(rm));
  fos_operand_gen uut (.sys_clk_in(clk), .rst_in(rst), .op_valid_in(v),
    .op_sel_in(sel), .imm_byte_in(b), .imm_pos_in(p),
    .source_operand_register_in(rm), .shift_kind_in(kd), .shift_amt_in(n),
    .set_flags_in(sf), .carry_flag_in(cf), .pc_load_addr_in(pa),
    .pc_load_in(pl), .op_valid_out(vo), .flexible_second_operand_out(op),
    .carry_update_out(cu), .carry_value_out(cvo), .iset_fault_out());
  function [33:0] f(input [2:0] s, k, input [7:0] y, m, input [4:0] h,
    input [31:0] r, input c);
    reg [63:0] t;
    reg [31:0] x;
    reg a, u;
    begin
      x = r; a = c; u = 0;
      case (s)
        3'h0: begin x = {24'h0, y} << h; u = x > 32'hFF; a = x[31]; end
        3'h1: x = {2{8'h00, y}};
        3'h2: x = {2{y, 8'h00}};
        3'h3: x = {4{y}};
        default: if (k == 3'h4) begin x = {c, r[31:1]}; a = r[0]; u = 1; end
        else if (m != 0) begin
          u = 1;
          t = k == 3'h0 ? {32'h0, r} << m : k == 3'h3 ? {r, r} >> m[4:0] :
            {r, 32'h0} >> m;
          if (k == 3'h2 && r[31]) t = t | ~({64{1'b1}} >> m);
          x = k == 3'h0 || k == 3'h3 ? t[31:0] : t[63:32];
          a = k == 3'h0 ? t[32] : k == 3'h3 ? x[31] : t[31];
        end
      endcase
      f = {u & sf, u & sf ? a : c, x};
    end
  endfunction
  task end_sim;
    begin
      if (q.size() != 0) begin
        miscompares = miscompares + 1;
        $display("MISMATCH pending_results exp 0 got %0d", q.size());
      end
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Results are compared at the falling edge, once the outputs have settled.
  always @(negedge clk) begin
    if (vo === 1'b1 && q.size() == 0) begin
      checks = checks + 1;
      miscompares = miscompares + 1;
      $display("MISMATCH op_valid_out exp 0 got 1");
    end else if (vo === 1'b1) begin
      e = q.pop_front();
      checks = checks + 1;
      if ({cu, cvo, op} !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH operand exp %h got %h", e, {cu, cvo, op});
      end
    end
  end
  initial begin
    g = $urandom(49974);
    repeat (5) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge clk);
      g = i ? $urandom : 32'h80000001;
      we <= i < 8; ix <= i; wd <= g;
      if (i < 8) sh[i] = g;
    end
    for (i = 0; i < 600; i = i + 1) begin
      @(posedge clk);
      g = $urandom % 8;
      n <= g == 0 ? 8'h00 : g == 1 ? 8'h01 : g[2] ? $urandom : 8'h1E + g[1:0];
      sel <= $urandom % 5; kd <= $urandom % 5; b <= $urandom; p <= $urandom;
      ix <= $urandom; sf <= $urandom; cf <= $urandom; v <= $urandom;
      pl <= $urandom; pa <= $urandom; we <= 0;
      @(negedge clk);
      if (v) q.push_back(f(sel, kd, b, n, p, sh[ix], cf));
    end
    @(posedge clk);
    v <= 0;
    repeat (3) @(posedge clk);
    end_sim;
  end
endmodule // fos_operand_gen_tb
